//--- src/scr_axil_slave.sv
// AXI4-Lite slave that turns bus transfers into register strobes
`timescale 1ns/100ps
module scr_axil_slave (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Write channels
  input wire logic [11:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // Read channels
  input wire logic [11:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Register side
  scr_reg_if.slave bus
);
  logic have_aw;
  logic have_w;
  logic have_ar;
  logic [5:0] aw_idx;
  logic [5:0] ar_idx;
  logic [7:0] wbyte;
  logic wlane;

  // Addresses above the decoded window fold onto an unmapped index
  function automatic logic [5:0] to_idx(input logic [11:0] a);
    return (a[11:8] == 4'h0) ? a[7:2] : scr_pkg::I_NONE;
  endfunction : to_idx

  // Strobes toward the bank
  assign bus.wr_en = have_aw && have_w;
  assign bus.wr_idx = aw_idx;
  assign bus.wr_data = wbyte;
  assign bus.wr_lane = wlane;
  assign bus.rd_en = have_ar;
  assign bus.rd_idx = ar_idx;

  // Write path: address and data taken in either order, one write in flight
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      have_aw <= 1'b0;
      have_w <= 1'b0;
      awready <= 1'b1;
      wready <= 1'b1;
      bvalid <= 1'b0;
      bresp <= scr_pkg::RESP_OKAY;
      aw_idx <= scr_pkg::I_NONE;
      wbyte <= 8'h00;
      wlane <= 1'b0;
    end else begin
      if (awvalid && awready) begin
        have_aw <= 1'b1;
        awready <= 1'b0;
        aw_idx <= to_idx(awaddr);
      end
      if (wvalid && wready) begin
        have_w <= 1'b1;
        wready <= 1'b0;
        wbyte <= wdata[7:0];
        wlane <= wstrb[0];
      end
      if (bus.wr_en) begin
        have_aw <= 1'b0;
        have_w <= 1'b0;
        bvalid <= 1'b1;
        bresp <= bus.wr_hit ? scr_pkg::RESP_OKAY : scr_pkg::RESP_DECERR;
      end
      if (bvalid && bready) begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  // Read path: data captured one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      have_ar <= 1'b0;
      arready <= 1'b1;
      rvalid <= 1'b0;
      rresp <= scr_pkg::RESP_OKAY;
      rdata <= 32'h00000000;
      ar_idx <= scr_pkg::I_NONE;
    end else begin
      if (arvalid && arready) begin
        have_ar <= 1'b1;
        arready <= 1'b0;
        ar_idx <= to_idx(araddr);
      end
      if (have_ar) begin
        have_ar <= 1'b0;
        rvalid <= 1'b1;
        rdata <= {24'h000000, bus.rd_data};
        rresp <= bus.rd_hit ? scr_pkg::RESP_OKAY : scr_pkg::RESP_DECERR;
      end
      if (rvalid && rready) begin
        rvalid <= 1'b0;
        arready <= 1'b1;
      end
    end
  end
endmodule : scr_axil_slave

//--- src/scr_config_regs.sv
// Serializer configuration register bank with AXI4-Lite access
`timescale 1ns/100ps
// Summary of operation
// - Own address in reg 0 bits 7:1 resets 1000000; peer address resets 1001000.
// - With the lock bit set, registers own_address_and_lock to 0x1F become read only.
// - Lock holds until power is removed or power-down input goes low.
// - Spread field 7:5 of reg 2 selects spread amount per its eight codes.
// - Spread field powers up as 000 or 001 from the strap pins.
// - Pixel range field 3:2 selects 12.5-25, 25-50 or 50-104 MHz.
// - Pixel range 11, the reset value, means automatic detection.
// - Bit rate field 1:0 selects 0.5-1, 1-2 or 2-3.12 Gbps.
// - Bit rate field 11, the reset value, means automatic detection.
// - Recal field 7:6 of reg 3: once, every 2, 16 or 256 ms.
// - Sawtooth divider 000000 means auto calibrate, else manual value.
// - Fault register bits 3:2 report the minus wire state.
// - Fault register bits 1:0 report the plus wire state.
// - Fault output goes low while a wire fault exists, high when normal.
module scr_config_regs #(
  parameter int unsigned RECAL_SHORT_CYC = scr_pkg::RECAL_SHORT_CYC,
  parameter int unsigned RECAL_MID_CYC = scr_pkg::RECAL_MID_CYC,
  parameter int unsigned RECAL_LONG_CYC = scr_pkg::RECAL_LONG_CYC
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [11:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  // AXI4-Lite write data and response
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read
  input wire logic [11:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Device pins
  input wire logic power_down_n,
  input wire logic [1:0] strap_pins_low,
  input wire logic link_locked,
  input wire logic [1:0] minus_wire_sense,
  input wire logic [1:0] plus_wire_sense,
  output logic line_fault_out_n,
  output logic irq,
  // Configuration toward the link
  output logic [6:0] own_bus_address,
  output logic [6:0] peer_bus_address,
  output logic config_write_lock,
  output logic [2:0] spread_amount,
  output logic [5:0] spread_tenths,
  output logic sound_channel_on,
  output logic [1:0] pixel_clock_range,
  output logic pixel_range_auto,
  output logic [1:0] bit_rate_range,
  output logic bit_rate_auto,
  output logic [1:0] spread_recal_interval,
  output logic recal_pulse,
  output logic [5:0] sawtooth_divider,
  output logic sawtooth_auto
);
  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  scr_reg_if bus ();
  logic [7:0] cfg [0:3];
  logic init_pending;
  logic [1:0] minus_q;
  logic [1:0] plus_q;
  logic fault_q;
  logic [2:0] irq_stat;
  logic [2:0] irq_mask;
  wire clr;
  wire locked;
  wire fault_now;
  wire wr_prot;
  wire wr_cfg_ok;
  wire wr_blocked;
  wire wr_istat;
  wire wr_imask;
  wire [7:0] wr_byte;
  wire [2:0] w1c;
  wire [2:0] irq_set;
  wire [2:0] next_irq_stat;

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  // Decoded register set, shared by the read and write answers
  function automatic logic is_mapped(input logic [5:0] i);
    return (i <= scr_pkg::I_CAL) || (i == scr_pkg::I_FLT) ||
           (i == scr_pkg::I_ISTAT) || (i == scr_pkg::I_IMASK);
  endfunction : is_mapped

  // Spread amount in tenths of a percent; codes 000 and 100 mean none
  function automatic logic [5:0] spread_lut(input logic [2:0] c);
    case (c)
      3'h1: return 6'h05;
      3'h2: return 6'h0F;
      3'h3: return 6'h14;
      3'h5: return 6'h0A;
      3'h6: return 6'h1E;
      3'h7: return 6'h28;
      default: return 6'h00;
    endcase
  endfunction : spread_lut

  // ----------------------------------------------------------------
  // Bus slave and recalibration timer
  // ----------------------------------------------------------------
  scr_axil_slave u_slave (
    .aclk(aclk),
    .aresetn(aresetn),
    .awaddr(awaddr),
    .awvalid(awvalid),
    .awready(awready),
    .wdata(wdata),
    .wstrb(wstrb),
    .wvalid(wvalid),
    .wready(wready),
    .bresp(bresp),
    .bvalid(bvalid),
    .bready(bready),
    .araddr(araddr),
    .arvalid(arvalid),
    .arready(arready),
    .rdata(rdata),
    .rresp(rresp),
    .rvalid(rvalid),
    .rready(rready),
    .bus(bus)
  );

  scr_recal_timer #(
    .CYC_SHORT(RECAL_SHORT_CYC),
    .CYC_MID(RECAL_MID_CYC),
    .CYC_LONG(RECAL_LONG_CYC)
  ) u_timer (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(link_locked && power_down_n),
    .mode(scr_pkg::scr_recal_t'(spread_recal_interval)),
    .tick(recal_pulse)
  );

  // ----------------------------------------------------------------
  // Write decode
  // ----------------------------------------------------------------
  // Power-down returns everything but the bus slave to defaults, which also drops the lock
  assign clr = !aresetn || !power_down_n;
  assign locked = cfg[scr_pkg::I_OWN[1:0]][scr_pkg::LOCK_BIT];
  assign wr_prot = bus.wr_idx <= scr_pkg::I_LOCK_END;
  // Locked writes to mapped registers are answered OKAY (unmapped ones DECERR) but never reach the storage
  assign wr_blocked = bus.wr_en && locked && wr_prot;
  assign wr_cfg_ok = bus.wr_en && bus.wr_lane && !locked &&
                     (bus.wr_idx <= scr_pkg::I_CAL);
  // Interrupt registers sit outside the locked range so they stay usable
  assign wr_istat = bus.wr_en && bus.wr_lane && (bus.wr_idx == scr_pkg::I_ISTAT);
  assign wr_imask = bus.wr_en && bus.wr_lane && (bus.wr_idx == scr_pkg::I_IMASK);
  assign wr_byte = (bus.wr_idx == scr_pkg::I_PEER) ?
                   (bus.wr_data & scr_pkg::PEER_WMASK) : bus.wr_data;
  assign bus.wr_hit = is_mapped(bus.wr_idx);

  // ----------------------------------------------------------------
  // Read decode
  // ----------------------------------------------------------------
  // Fault register shows the sampled wire states; reserved bits read zero
  assign bus.rd_hit = is_mapped(bus.rd_idx);
  assign bus.rd_data = (bus.rd_idx <= scr_pkg::I_CAL) ? cfg[bus.rd_idx[1:0]] :
                       (bus.rd_idx == scr_pkg::I_FLT) ? {4'h0, minus_q, plus_q} :
                       (bus.rd_idx == scr_pkg::I_ISTAT) ? {5'h00, irq_stat} :
                       (bus.rd_idx == scr_pkg::I_IMASK) ? {5'h00, irq_mask} :
                       8'h00;

  // ----------------------------------------------------------------
  // Configuration storage
  // ----------------------------------------------------------------
  // Strap level is caught by the first clocked cycle after reset release
  always_ff @(posedge aclk) begin
    if (clr) begin
      cfg[0] <= scr_pkg::RST_OWN;
      cfg[1] <= scr_pkg::RST_PEER;
      cfg[2] <= scr_pkg::RST_SPRD;
      cfg[3] <= scr_pkg::RST_CAL;
      init_pending <= 1'b1;
    end else begin
      init_pending <= 1'b0;
      if (init_pending) begin
        cfg[2][scr_pkg::SS_LSB +: 3] <= {2'b00, strap_pins_low[scr_pkg::STRAP_SS_BIT]};
      end
      if (wr_cfg_ok) begin
        cfg[bus.wr_idx[1:0]] <= wr_byte;
      end
    end
  end

  // Field views of the storage
  assign own_bus_address = cfg[0][7:1];
  assign peer_bus_address = cfg[1][7:1];
  assign config_write_lock = locked;
  assign spread_amount = cfg[2][scr_pkg::SS_LSB +: 3];
  assign sound_channel_on = cfg[2][scr_pkg::SOUND_BIT];
  assign pixel_clock_range = cfg[2][scr_pkg::PIX_LSB +: 2];
  assign bit_rate_range = cfg[2][scr_pkg::RATE_LSB +: 2];
  assign spread_recal_interval = cfg[3][scr_pkg::RECAL_LSB +: 2];
  assign sawtooth_divider = cfg[3][5:0];

  // Decoded modes, registered so every output leaves a flip-flop
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      spread_tenths <= 6'h00;
      pixel_range_auto <= 1'b1;
      bit_rate_auto <= 1'b1;
      sawtooth_auto <= 1'b1;
    end else begin
      spread_tenths <= spread_lut(spread_amount);
      pixel_range_auto <= pixel_clock_range == scr_pkg::RANGE_AUTO;
      bit_rate_auto <= bit_rate_range == scr_pkg::RANGE_AUTO;
      sawtooth_auto <= sawtooth_divider == scr_pkg::SAW_AUTO;
    end
  end

  // ----------------------------------------------------------------
  // Line fault status and interrupts
  // ----------------------------------------------------------------
  // Detector codes pass straight through; no filter, software may add one
  assign fault_now = (minus_q != scr_pkg::WIRE_OK) || (plus_q != scr_pkg::WIRE_OK);
  assign irq_set = {wr_blocked, fault_q && !fault_now, !fault_q && fault_now};
  assign w1c = wr_istat ? bus.wr_data[2:0] : 3'h0;
  // A new event in the clearing cycle survives: set is applied last
  assign next_irq_stat = (irq_stat & ~w1c) | irq_set;

  always_ff @(posedge aclk) begin
    if (clr) begin
      minus_q <= scr_pkg::WIRE_OK;
      plus_q <= scr_pkg::WIRE_OK;
      fault_q <= 1'b0;
      line_fault_out_n <= 1'b1;
      irq_stat <= 3'h0;
      irq_mask <= 3'h0;
      irq <= 1'b0;
    end else begin
      minus_q <= minus_wire_sense;
      plus_q <= plus_wire_sense;
      fault_q <= fault_now;
      line_fault_out_n <= !fault_now;
      irq_stat <= next_irq_stat;
      irq_mask <= wr_imask ? bus.wr_data[2:0] : irq_mask;
      irq <= |(irq_stat & irq_mask);
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_addr_reset;
    $past(!power_down_n) |-> own_bus_address == 7'h40 && peer_bus_address == 7'h48;
  endproperty
  a_addr_reset: assert property (p_addr_reset) else $error("address reset wrong");

  property p_lock_holds_cfg;
    locked && power_down_n && bus.wr_en && bus.wr_idx <= scr_pkg::I_CAL
      |=> $stable(cfg[0]) && $stable(cfg[1]) && $stable(cfg[2]) && $stable(cfg[3]);
  endproperty
  a_lock_holds_cfg: assert property (p_lock_holds_cfg) else $error("locked write landed");

  property p_lock_sticky;
    config_write_lock && power_down_n |=> config_write_lock;
  endproperty
  a_lock_sticky: assert property (p_lock_sticky) else $error("lock dropped");

  property p_blocked_okay;
    bus.wr_en && locked && power_down_n && bus.wr_idx <= scr_pkg::I_CAL
      |=> bvalid && bresp == 2'h0 && irq_stat[2];
  endproperty
  a_blocked_okay: assert property (p_blocked_okay) else $error("blocked write answer");

  property p_spread_max;
    spread_amount == 3'h7 [*2] |-> spread_tenths == 6'h28;
  endproperty
  a_spread_max: assert property (p_spread_max) else $error("spread 111 not 4 pct");

  property p_spread_none;
    spread_amount == 3'h4 [*2] |-> spread_tenths == 6'h00;
  endproperty
  a_spread_none: assert property (p_spread_none) else $error("spread 100 not none");

  property p_strap_load;
    $fell(init_pending) |-> spread_amount == {2'b00, $past(strap_pins_low[0])};
  endproperty
  a_strap_load: assert property (p_strap_load) else $error("strap default wrong");

  property p_pix_auto;
    pixel_clock_range == 2'h3 [*2] |-> pixel_range_auto;
  endproperty
  a_pix_auto: assert property (p_pix_auto) else $error("pixel auto missing");

  property p_rate_manual;
    bit_rate_range == 2'h1 [*2] |-> !bit_rate_auto;
  endproperty
  a_rate_manual: assert property (p_rate_manual) else $error("rate auto wrong");

  property p_recal_once;
    $rose(link_locked) && power_down_n && spread_recal_interval == 2'h0
      |=> recal_pulse ##1 !recal_pulse [*3];
  endproperty
  a_recal_once: assert property (p_recal_once) else $error("single recal wrong");

  property p_saw_manual;
    sawtooth_divider != 6'h00 [*2] |-> !sawtooth_auto;
  endproperty
  a_saw_manual: assert property (p_saw_manual) else $error("divider auto wrong");

  property p_fault_read;
    bus.rd_en && bus.rd_idx == 6'h08 |=> rdata[3:0] == {$past(minus_q), $past(plus_q)};
  endproperty
  a_fault_read: assert property (p_fault_read) else $error("fault read wrong");

  property p_fault_pin;
    // Reset also holds the sampled codes, so it must be off for the whole look-back
    (power_down_n && aresetn) [*3] ##0 ($past(minus_wire_sense, 2) != 2'h2)
      |-> !line_fault_out_n;
  endproperty
  a_fault_pin: assert property (p_fault_pin) else $error("fault pin not low");

  c_blocked: cover property (wr_blocked);
  c_fault_on: cover property (irq_set[0]);
  c_recal: cover property (recal_pulse);
  c_irq: cover property (irq);
endmodule : scr_config_regs

//--- src/scr_pkg.sv
// Shared constants and types of the serializer configuration register block
package scr_pkg;
  // ----------------------------------------------------------------
  // Register indexes (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [5:0] I_OWN = 6'h00;
  localparam logic [5:0] I_PEER = 6'h01;
  localparam logic [5:0] I_SPRD = 6'h02;
  localparam logic [5:0] I_CAL = 6'h03;
  localparam logic [5:0] I_FLT = 6'h08;
  localparam logic [5:0] I_ISTAT = 6'h20;
  localparam logic [5:0] I_IMASK = 6'h21;
  localparam logic [5:0] I_LOCK_END = 6'h1F;
  localparam logic [5:0] I_NONE = 6'h3F;
  // ----------------------------------------------------------------
  // Reset values and write masks
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_OWN = 8'h80;
  localparam logic [7:0] RST_PEER = 8'h90;
  localparam logic [7:0] RST_SPRD = 8'h1F;
  localparam logic [7:0] RST_CAL = 8'h00;
  localparam logic [7:0] PEER_WMASK = 8'hFE;
  // ----------------------------------------------------------------
  // Field positions and values
  // ----------------------------------------------------------------
  localparam int LOCK_BIT = 0;
  localparam int SOUND_BIT = 4;
  localparam int SS_LSB = 5;
  localparam int PIX_LSB = 2;
  localparam int RATE_LSB = 0;
  localparam int RECAL_LSB = 6;
  localparam int STRAP_SS_BIT = 0;
  localparam logic [1:0] RANGE_AUTO = 2'h3;
  localparam logic [1:0] WIRE_OK = 2'h2;
  localparam logic [5:0] SAW_AUTO = 6'h00;
  // ----------------------------------------------------------------
  // Interrupt bits and bus answers
  // ----------------------------------------------------------------
  localparam int IRQ_FLT_ON = 0;
  localparam int IRQ_FLT_OFF = 1;
  localparam int IRQ_BLOCKED = 2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  // ----------------------------------------------------------------
  // Recalibration timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_KHZ = 40000;
  localparam int unsigned RECAL_SHORT_MS = 2;
  localparam int unsigned RECAL_MID_MS = 16;
  localparam int unsigned RECAL_LONG_MS = 256;
  localparam int unsigned RECAL_SHORT_CYC = RECAL_SHORT_MS * CLK_KHZ;
  localparam int unsigned RECAL_MID_CYC = RECAL_MID_MS * CLK_KHZ;
  localparam int unsigned RECAL_LONG_CYC = RECAL_LONG_MS * CLK_KHZ;
  typedef enum logic [1:0] {
    RECAL_ONCE = 2'h0,
    RECAL_SHORT = 2'h1,
    RECAL_MID = 2'h2,
    RECAL_LONG = 2'h3
  } scr_recal_t;
endpackage : scr_pkg

//--- src/scr_recal_timer.sv
// Spread-modulation recalibration interval timer
`timescale 1ns/100ps
module scr_recal_timer #(
  parameter int unsigned CYC_SHORT = scr_pkg::RECAL_SHORT_CYC,
  parameter int unsigned CYC_MID = scr_pkg::RECAL_MID_CYC,
  parameter int unsigned CYC_LONG = scr_pkg::RECAL_LONG_CYC
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Control
  input wire logic run,
  input wire scr_pkg::scr_recal_t mode,
  // Result
  output logic tick
);
  logic [23:0] count;
  logic fired;
  wire [23:0] limit;

  // Last count of the selected interval
  assign limit = (mode == scr_pkg::RECAL_SHORT) ? 24'(CYC_SHORT - 1) :
                 (mode == scr_pkg::RECAL_MID) ? 24'(CYC_MID - 1) : 24'(CYC_LONG - 1);

  // Idle while unlocked; a mode change re-aims the compare without restart
  always_ff @(posedge aclk) begin
    if (!aresetn || !run) begin
      count <= 24'h000000;
      fired <= 1'b0;
      tick <= 1'b0;
    end else if (mode == scr_pkg::RECAL_ONCE) begin
      tick <= !fired;
      fired <= 1'b1;
      count <= 24'h000000;
    end else if (count >= limit) begin
      tick <= 1'b1;
      fired <= 1'b1;
      count <= 24'h000000;
    end else begin
      tick <= 1'b0;
      count <= count + 24'h000001;
    end
  end
endmodule : scr_recal_timer

//--- src/scr_reg_if.sv
// Register access carrier between the bus slave and the register bank
`timescale 1ns/100ps
interface scr_reg_if;
  logic wr_en;
  logic [5:0] wr_idx;
  logic [7:0] wr_data;
  logic wr_lane;
  logic wr_hit;
  logic rd_en;
  logic [5:0] rd_idx;
  logic [7:0] rd_data;
  logic rd_hit;
  modport slave (output wr_en, wr_idx, wr_data, wr_lane, rd_en, rd_idx,
                 input wr_hit, rd_data, rd_hit);
  modport bank (input wr_en, wr_idx, wr_data, wr_lane, rd_en, rd_idx,
                output wr_hit, rd_data, rd_hit);
endinterface : scr_reg_if

//--- test/scr_wire_model.sv
// Cable wire model that presents detector codes for both wires
`timescale 1ns/100ps
module scr_wire_model (
  // Wire conditions chosen by the bench
  input wire logic [1:0] minus_state,
  input wire logic [1:0] plus_state,
  // Detector codes toward the block
  output logic [1:0] minus_sense,
  output logic [1:0] plus_sense
);
  // Each code is held steadily, as a real detector does while the fault lasts
  assign minus_sense = minus_state;
  assign plus_sense = plus_state;
endmodule : scr_wire_model

//--- test/serializer_config_regs_bench.sv
// Self-checking bench of the serializer configuration register block
`timescale 1ns/100ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin n_mismatch++; \
  $display("ERROR %0t: got %h expected %h", $time, a, b); end end
module serializer_config_regs_bench;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0] wstrb = 4'hF;
  logic [1:0] strap = 2'h1;
  logic power_down_n = 1, link_locked = 0, awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, m_st = 2'h2, p_st = 2'h2, m_sn, p_sn;
  logic line_fault_out_n, irq, config_write_lock, sound_channel_on, recal_pulse;
  logic pixel_range_auto, bit_rate_auto, sawtooth_auto;
  logic [6:0] own_bus_address, peer_bus_address;
  logic [2:0] spread_amount;
  logic [5:0] spread_tenths, sawtooth_divider;
  logic [1:0] pixel_clock_range, bit_rate_range, spread_recal_interval;
  int n_mismatch = 0, comparisons = 0, i, n;
  int tenths[8] = '{0, 5, 15, 20, 0, 10, 30, 40};
  // ------------------------------------------------------------
  // Clock, device and cable model
  // ------------------------------------------------------------
  always #12.5 aclk = ~aclk;
  scr_config_regs #(.RECAL_SHORT_CYC(8), .RECAL_MID_CYC(16), .RECAL_LONG_CYC(32)) dut (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .power_down_n(power_down_n), .strap_pins_low(strap), .link_locked(link_locked),
    .minus_wire_sense(m_sn), .plus_wire_sense(p_sn), .line_fault_out_n(line_fault_out_n),
    .irq(irq), .own_bus_address(own_bus_address), .peer_bus_address(peer_bus_address),
    .config_write_lock(config_write_lock), .spread_amount(spread_amount),
    .spread_tenths(spread_tenths), .sound_channel_on(sound_channel_on),
    .pixel_clock_range(pixel_clock_range), .pixel_range_auto(pixel_range_auto),
    .bit_rate_range(bit_rate_range), .bit_rate_auto(bit_rate_auto),
    .spread_recal_interval(spread_recal_interval), .recal_pulse(recal_pulse),
    .sawtooth_divider(sawtooth_divider), .sawtooth_auto(sawtooth_auto));
  scr_wire_model wires (.minus_state(m_st), .plus_state(p_st), .minus_sense(m_sn),
    .plus_sense(p_sn));
  // ------------------------------------------------------------
  // Bus tasks and closing report
  // ------------------------------------------------------------
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : stop_test
  task automatic hang;
    n_mismatch++;
    $display("ERROR %0t: no answer from the bus", $time);
    stop_test();
  endtask : hang
  // Both channels offered at once; each released at its own handshake
  // Ready stays high between calls, so back-to-back calls never drive it twice in one step
  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
    int k;
    bit pa = 1, pw = 1, pb = 1;
    awaddr <= a; wdata <= {24'h0, d}; awvalid <= 1; wvalid <= 1; bready <= 1;
    for (k = 0; k < 50 && pb; k++) begin
      @(posedge aclk);
      if (pa && awready) begin awvalid <= 0; pa = 0; end
      if (pw && wready) begin wvalid <= 0; pw = 0; end
      if (bvalid) begin pb = 0; `CHK(bresp, er) end
    end
    if (pb) hang();
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [7:0] ed, input logic [1:0] er);
    int k;
    bit pa = 1, pr = 1;
    araddr <= a; arvalid <= 1; rready <= 1;
    for (k = 0; k < 50 && pr; k++) begin
      @(posedge aclk);
      if (pa && arready) begin arvalid <= 0; pa = 0; end
      if (rvalid) begin pr = 0; `CHK(rdata, {24'h0, ed}) `CHK(rresp, er) end
    end
    if (pr) hang();
  endtask : rd
  // ------------------------------------------------------------
  // Test sequence
  // ------------------------------------------------------------
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1;
    repeat (2) @(posedge aclk);
    rd(12'h000, 8'h80, 2'h0);
    rd(12'h004, 8'h90, 2'h0);
    rd(12'h008, 8'h3F, 2'h0);
    rd(12'h00C, 8'h00, 2'h0);
    rd(12'h020, 8'h0A, 2'h0);
    `CHK(own_bus_address, 7'h40)
    `CHK(peer_bus_address, 7'h48)
    `CHK(spread_amount, 3'h1)
    `CHK(sound_channel_on, 1'b1)
    $display("test reset values done");
    // Every spread code, with every range code in the two range fields
    for (i = 0; i < 8; i++) begin
      wr(12'h008, {i[2:0], 1'b0, i[1:0], i[1:0]}, 2'h0);
      repeat (2) @(posedge aclk);
      `CHK(spread_tenths, 6'(tenths[i]))
      `CHK(spread_amount, i[2:0])
      `CHK(pixel_clock_range, i[1:0])
      `CHK(bit_rate_range, i[1:0])
      `CHK(pixel_range_auto, i[1:0] == 2'h3)
      `CHK(bit_rate_auto, i[1:0] == 2'h3)
    end
    $display("test spread and ranges done");
    // Recalibration pulses counted over a fixed window after lock is gained
    for (i = 0; i < 4; i++) begin
      wr(12'h00C, {i[1:0], 6'(i)}, 2'h0);
      link_locked <= 1;
      n = 0;
      repeat (36) begin @(posedge aclk); n += (recal_pulse === 1'b1); end
      `CHK(n, (i == 0) ? 1 : 36 / (8 << (i - 1)))
      `CHK(sawtooth_auto, i == 0)
      `CHK(sawtooth_divider, 6'(i))
      `CHK(spread_recal_interval, i[1:0])
      link_locked <= 0;
      repeat (4) @(posedge aclk);
    end
    $display("test recalibration done");
    // Wire faults: both fields differ so a swapped field shows up
    for (i = 0; i < 4; i++) begin
      m_st <= i[1:0]; p_st <= 2'h3 - i[1:0];
      repeat (3) @(posedge aclk);
      `CHK(line_fault_out_n, 1'b0)
      rd(12'h020, {4'h0, i[1:0], 2'h3 - i[1:0]}, 2'h0);
    end
    m_st <= 2'h2; p_st <= 2'h2;
    repeat (3) @(posedge aclk);
    `CHK(line_fault_out_n, 1'b1)
    wr(12'h020, 8'hFF, 2'h0);
    rd(12'h020, 8'h0A, 2'h0);
    rd(12'h080, 8'h03, 2'h0);
    `CHK(irq, 1'b0)
    wr(12'h084, 8'h01, 2'h0);
    repeat (2) @(posedge aclk);
    `CHK(irq, 1'b1)
    wr(12'h080, 8'h01, 2'h0);
    repeat (2) @(posedge aclk);
    `CHK(irq, 1'b0)
    rd(12'h080, 8'h02, 2'h0);
    $display("test line fault and interrupt done");
    // Lock, refused writes, unmapped access, then release by power-down
    wr(12'h000, 8'h81, 2'h0);
    `CHK(config_write_lock, 1'b1)
    wr(12'h004, 8'h22, 2'h0);
    wr(12'h000, 8'h10, 2'h0);
    rd(12'h004, 8'h90, 2'h0);
    rd(12'h000, 8'h81, 2'h0);
    rd(12'h080, 8'h06, 2'h0);
    rd(12'h100, 8'h00, 2'h3);
    wr(12'h100, 8'h00, 2'h3);
    // Strap moved low so the power-down release must load spread code 000
    power_down_n <= 0;
    strap <= 2'h0;
    repeat (2) @(posedge aclk);
    power_down_n <= 1;
    repeat (2) @(posedge aclk);
    `CHK(config_write_lock, 1'b0)
    rd(12'h000, 8'h80, 2'h0);
    rd(12'h008, 8'h1F, 2'h0);
    wr(12'h004, 8'h23, 2'h0);
    rd(12'h004, 8'h22, 2'h0);
    // A write without the low byte lane must leave the register alone
    wstrb <= 4'h0;
    wr(12'h004, 8'h44, 2'h0);
    wstrb <= 4'hF;
    rd(12'h004, 8'h22, 2'h0);
    $display("test write lock done");
    stop_test();
  end
endmodule : serializer_config_regs_bench
